/* File: hw/gdfcr_defs.vh */
// constants for the gate driver fault and control register bank
`ifndef GDFCR_DEFS_VH
`define GDFCR_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define GDFCR_ADDR_FAULT_PRIMARY 3'h0
`define GDFCR_ADDR_FAULT_DETAIL 3'h1
`define GDFCR_ADDR_DRIVER_CTRL1 3'h2
`define GDFCR_ADDR_LAST 3'h5

// ----------------------------------------------------------------
// frame format
// ----------------------------------------------------------------
`define GDFCR_FRAME_BITS 5'h10
`define GDFCR_ADDR_DONE_BITS 5'h03
`define GDFCR_SDO_LEAD_BITS 5'h04
`define GDFCR_CNT_SAT 5'h11
`define GDFCR_DATA_W 12

// ----------------------------------------------------------------
// primary fault status fields
// ----------------------------------------------------------------
`define GDFCR_FP_SUMMARY 11
`define GDFCR_FP_SUPPLY_UV 10
`define GDFCR_FP_PUMP_UV 8
`define GDFCR_FP_SWITCH_OC 7
`define GDFCR_FP_SHUNT_OC 6
`define GDFCR_FP_THERM_WARN 5
`define GDFCR_FP_THERM_SHUT 4
`define GDFCR_FP_REG_OC 2
`define GDFCR_FP_REG_UV 1
`define GDFCR_FP_REG_OV 0

// ----------------------------------------------------------------
// control register fields and values
// ----------------------------------------------------------------
`define GDFCR_CR_CLEAR 11
`define GDFCR_CR_LOCK_HI 10
`define GDFCR_CR_LOCK_LO 8
`define GDFCR_CR_PUMP_UV_EN 7
`define GDFCR_CR_BEMF_HOLD 6
`define GDFCR_CR_WARN_PIN 5
`define GDFCR_CR_PWM_MODE 4
`define GDFCR_CR_DEAD_HI 3
`define GDFCR_CR_DEAD_LO 2
`define GDFCR_CR_CS_MODE 1
`define GDFCR_CR_CS_HOLD 0
`define GDFCR_LOCK_CODE 3'h6
`define GDFCR_UNLOCK_CODE 3'h3
`define GDFCR_CFG_RESET 8'hA4

`endif

/* File: hw/gdfcr_regs.v */
// fault status and first control registers behind a 16-bit serial slave
//
// Overview of operation
// - summary fault bit 11 sets on any detected fault except thermal warning and holds until cleared
// - latched faults except thermal warning clear by clear bit or enable low pulse
// - supply undervoltage latches primary bit 10
// - charge pump undervoltage latches primary bit 8
// - any switch drain-source overcurrent latches primary bit 7
// - any shunt amplifier overcurrent latches primary bit 6
// - thermal warning bit 5 follows the warning indication, no clear needed
// - thermal shutdown latches bit 4 until clear bit or enable pulse
// - regulator overcurrent, undervoltage, overvoltage latch bits 2, 1, 0
// - detail bits 11..9 latch amplifier A, B, C overcurrent
// - detail bits 8..3 latch the six switch trips; bits 2..0 zero
// - writing 1 to control bit 11 clears all latched faults
// - clear bit self-clears and reads as 0
// - lock field 110 blocks other writes, 011 unlocks, else no change
// - bit 7 set makes pump undervoltage act; clear only reports it
// - bit 6 enables back-EMF amplifier sample-hold, default 0
// - bit 5 routes thermal warning to the fault pin, default 1
// - bit 4 picks PWM input mode, else independent inputs, default 0
// - bits 3..2 pick dead time 100/150/250/450 ns, default 01
// - bit 1 picks on-resistance sensing, else shunt sensing, default 0
// - bit 0 enables current amplifier sample-hold, default 0
// - frame is 16 bits msb first: rw, 3 address bits, 12 data bits
// - out-of-range address or wrong bit count discards the frame

`include "gdfcr_defs.vh"

module gdfcr_regs (
  input wire clk_sys,
  input wire nrst,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe_n,
  input wire enable_pin,
  input wire supply_uv_cmp,
  input wire pump_uv_cmp,
  input wire thermal_warn_cmp,
  input wire thermal_shut_cmp,
  input wire regulator_oc_cmp,
  input wire regulator_uv_cmp,
  input wire regulator_ov_cmp,
  input wire amp_a_overcurrent,
  input wire amp_b_overcurrent,
  input wire amp_c_overcurrent,
  input wire phase_a_high_switch_trip,
  input wire phase_a_low_switch_trip,
  input wire phase_b_high_switch_trip,
  input wire phase_b_low_switch_trip,
  input wire phase_c_high_switch_trip,
  input wire phase_c_low_switch_trip,
  output wire error_indicator_pin_n,
  output wire pump_uv_shutdown,
  output wire pump_uv_protect_on,
  output wire backemf_hold_on,
  output wire thermal_warn_to_pin,
  output wire pwm_mode_on,
  output wire [1:0] dead_time_sel,
  output wire rdson_sense_on,
  output wire current_amp_hold_on
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam SY_W = 20;
  localparam SY_CS = 0;
  localparam SY_SCLK = 1;
  localparam SY_SDI = 2;
  localparam SY_EN = 3;
  localparam SY_WARN = 6;
  localparam NLAT = 15;

  wire [SY_W-1:0] raw_in;
  reg [SY_W-1:0] sy1_r;
  reg [SY_W-1:0] sy2_r;

  assign raw_in = {phase_c_low_switch_trip, phase_c_high_switch_trip,
    phase_b_low_switch_trip, phase_b_high_switch_trip,
    phase_a_low_switch_trip, phase_a_high_switch_trip,
    amp_c_overcurrent, amp_b_overcurrent, amp_a_overcurrent,
    regulator_ov_cmp, regulator_uv_cmp, regulator_oc_cmp,
    thermal_shut_cmp, thermal_warn_cmp, pump_uv_cmp, supply_uv_cmp,
    enable_pin, spi_sdi, spi_sclk, spi_cs_n};

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sy1_r <= 20'h00009;
      sy2_r <= 20'h00009;
    end else begin
      sy1_r <= raw_in;
      sy2_r <= sy1_r;
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  reg cs_prev_r;
  reg sclk_prev_r;
  reg en_prev_r;
  wire cs_act;
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;
  wire sclk_rise;
  wire en_rise;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
      en_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= sy2_r[SY_CS];
      sclk_prev_r <= sy2_r[SY_SCLK];
      en_prev_r <= sy2_r[SY_EN];
    end
  end

  assign cs_act = ~sy2_r[SY_CS] & ~cs_prev_r;
  assign cs_fall = ~sy2_r[SY_CS] & cs_prev_r;
  assign cs_rise = sy2_r[SY_CS] & ~cs_prev_r;
  assign sclk_fall = cs_act & sclk_prev_r & ~sy2_r[SY_SCLK];
  assign sclk_rise = cs_act & ~sclk_prev_r & sy2_r[SY_SCLK];
  assign en_rise = sy2_r[SY_EN] & ~en_prev_r;

  // ----------------------------------------------------------------
  // fault latches
  // ----------------------------------------------------------------
  // order: supply, pump, shutdown, reg oc, reg uv, reg ov, amp a..c,
  // then switches a-high, a-low, b-high, b-low, c-high, c-low
  wire [NLAT-1:0] fault_cond;
  reg [NLAT-1:0] lat_r;
  reg sum_r;
  reg warn_r;
  reg clr_req_r;
  wire clr_all;

  assign fault_cond = {sy2_r[19:7], sy2_r[5:4]};
  assign clr_all = clr_req_r | en_rise;

  genvar gi;
  generate
    for (gi = 0; gi < NLAT; gi = gi + 1) begin : g_lat
      // set wins over a clear in the same cycle
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          lat_r[gi] <= 1'b0;
        end else begin
          lat_r[gi] <= (lat_r[gi] & ~clr_all) | fault_cond[gi];
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sum_r <= 1'b0;
      warn_r <= 1'b0;
    end else begin
      sum_r <= (sum_r & ~clr_all) | (|fault_cond);
      warn_r <= sy2_r[SY_WARN];
    end
  end

  // ----------------------------------------------------------------
  // control register state
  // ----------------------------------------------------------------
  reg [7:0] cfg_r;
  reg lock_r;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  function [11:0] rd_word;
    input [2:0] addr;
    input [NLAT-1:0] lat;
    input sum;
    input warn;
    input lock;
    input [7:0] cfg;
    begin
      case (addr)
        `GDFCR_ADDR_FAULT_PRIMARY: begin
          rd_word = {sum, lat[0], 1'b0, lat[1], |lat[14:9], |lat[8:6],
            warn, lat[2], 1'b0, lat[3], lat[4], lat[5]};
        end
        `GDFCR_ADDR_FAULT_DETAIL: begin
          rd_word = {lat[6], lat[7], lat[8], lat[9], lat[10], lat[11],
            lat[12], lat[13], lat[14], 3'h0};
        end
        `GDFCR_ADDR_DRIVER_CTRL1: begin
          rd_word = {1'b0, (lock ? `GDFCR_LOCK_CODE : `GDFCR_UNLOCK_CODE), cfg};
        end
        default: begin
          rd_word = 12'h000;
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  reg [4:0] fcnt_r;
  reg [4:0] rcnt_r;
  reg [15:0] shin_r;
  reg [11:0] shout_r;
  reg sdo_r;
  reg sdo_oe_n_r;
  wire [2:0] cur_addr;
  wire frame_ok;
  wire frame_wr_ctrl;
  wire [11:0] wdata;
  wire [2:0] wlock;

  assign cur_addr = {shin_r[1:0], sy2_r[SY_SDI]};
  assign wdata = shin_r[11:0];
  assign wlock = wdata[`GDFCR_CR_LOCK_HI:`GDFCR_CR_LOCK_LO];
  assign frame_ok = cs_rise & (fcnt_r == `GDFCR_FRAME_BITS)
    & (shin_r[14:12] <= `GDFCR_ADDR_LAST);
  assign frame_wr_ctrl = frame_ok & ~shin_r[15]
    & (shin_r[14:12] == `GDFCR_ADDR_DRIVER_CTRL1);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fcnt_r <= 5'h00;
      rcnt_r <= 5'h00;
      shin_r <= 16'h0000;
    end else if (cs_fall) begin
      fcnt_r <= 5'h00;
      rcnt_r <= 5'h00;
      shin_r <= 16'h0000;
    end else begin
      if (sclk_fall) begin
        shin_r <= {shin_r[14:0], sy2_r[SY_SDI]};
        if (fcnt_r != `GDFCR_CNT_SAT) begin
          fcnt_r <= fcnt_r + 5'h01;
        end
      end
      if (sclk_rise && rcnt_r != `GDFCR_CNT_SAT) begin
        rcnt_r <= rcnt_r + 5'h01;
      end
    end
  end

  // reply: four low bits, then the addressed register msb first
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shout_r <= 12'h000;
      sdo_r <= 1'b0;
      sdo_oe_n_r <= 1'b1;
    end else begin
      sdo_oe_n_r <= sy2_r[SY_CS];
      if (cs_fall) begin
        shout_r <= 12'h000;
        sdo_r <= 1'b0;
      end else if (sclk_fall && fcnt_r == `GDFCR_ADDR_DONE_BITS) begin
        shout_r <= rd_word(cur_addr, lat_r, sum_r, warn_r, lock_r, cfg_r);
      end else if (sclk_rise) begin
        if (rcnt_r < `GDFCR_SDO_LEAD_BITS) begin
          sdo_r <= 1'b0;
        end else begin
          sdo_r <= shout_r[11];
          shout_r <= {shout_r[10:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= `GDFCR_CFG_RESET;
      lock_r <= 1'b0;
      clr_req_r <= 1'b0;
    end else begin
      clr_req_r <= 1'b0;
      if (frame_wr_ctrl) begin
        if (wlock == `GDFCR_LOCK_CODE) begin
          lock_r <= 1'b1;
        end else if (wlock == `GDFCR_UNLOCK_CODE) begin
          lock_r <= 1'b0;
        end
        if (!lock_r) begin
          cfg_r <= wdata[7:0];
          clr_req_r <= wdata[`GDFCR_CR_CLEAR];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin and protection outputs
  // ----------------------------------------------------------------
  reg err_n_r;
  reg pump_trip_r;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_n_r <= 1'b1;
      pump_trip_r <= 1'b0;
    end else begin
      err_n_r <= ~(sum_r | (warn_r & cfg_r[`GDFCR_CR_WARN_PIN]));
      pump_trip_r <= lat_r[1] & cfg_r[`GDFCR_CR_PUMP_UV_EN];
    end
  end

  assign spi_sdo = sdo_r;
  assign spi_sdo_oe_n = sdo_oe_n_r;
  assign error_indicator_pin_n = err_n_r;
  assign pump_uv_shutdown = pump_trip_r;
  assign pump_uv_protect_on = cfg_r[`GDFCR_CR_PUMP_UV_EN];
  assign backemf_hold_on = cfg_r[`GDFCR_CR_BEMF_HOLD];
  assign thermal_warn_to_pin = cfg_r[`GDFCR_CR_WARN_PIN];
  assign pwm_mode_on = cfg_r[`GDFCR_CR_PWM_MODE];
  assign dead_time_sel = cfg_r[`GDFCR_CR_DEAD_HI:`GDFCR_CR_DEAD_LO];
  assign rdson_sense_on = cfg_r[`GDFCR_CR_CS_MODE];
  assign current_amp_hold_on = cfg_r[`GDFCR_CR_CS_HOLD];

endmodule // gdfcr_regs

/* File: tb/gdfcr_regs_props.sv */
// concurrent checks on the ports of the register bank
module gdfcr_regs_props (
  input wire clk_sys,
  input wire nrst,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdo,
  input wire spi_sdo_oe_n,
  input wire enable_pin,
  input wire supply_uv_cmp,
  input wire pump_uv_cmp,
  input wire thermal_warn_cmp,
  input wire error_indicator_pin_n,
  input wire pump_uv_shutdown,
  input wire pump_uv_protect_on,
  input wire thermal_warn_to_pin,
  input wire pwm_mode_on,
  input wire [1:0] dead_time_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hi_cnt_r;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ----
  // cycles since frame select went high
  // ----
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_r <= 4'h0;
    end else if (!spi_cs_n) begin
      hi_cnt_r <= 4'h0;
    end else if (hi_cnt_r != 4'hF) begin
      hi_cnt_r <= hi_cnt_r + 4'h1;
    end
  end
  oe_idle_a: assert property (spi_cs_n [*4] |-> spi_sdo_oe_n)
    else $error("sdo driven while deselected");
  sdo_edge_a: assert property ($changed(spi_sdo) && !spi_cs_n && !$past(spi_cs_n, 4)
    |-> spi_sclk || $past(spi_sclk)) else $error("sdo moved off a rising edge");
  uv_pin_a: assert property ($rose(supply_uv_cmp) |-> ##[2:5] !error_indicator_pin_n)
    else $error("fault pin missed supply fault");
  pin_hold_a: assert property ((spi_cs_n && enable_pin && !thermal_warn_cmp) [*8]
    ##0 !error_indicator_pin_n |=> !error_indicator_pin_n) else $error("fault pin dropped");
  warn_pin_a: assert property ((thermal_warn_cmp && thermal_warn_to_pin) [*5]
    |-> !error_indicator_pin_n) else $error("warning not on fault pin");
  rst_cfg_a: assert property ($rose(nrst) |-> dead_time_sel == 2'b01
    && pump_uv_protect_on && thermal_warn_to_pin && !pwm_mode_on) else $error("bad reset cfg");
  ctrl_frame_a: assert property ($changed({pump_uv_protect_on, thermal_warn_to_pin,
    pwm_mode_on, dead_time_sel}) |-> hi_cnt_r >= 4'h2 && hi_cnt_r <= 4'h7)
    else $error("control moved outside a frame end");
  pump_act_a: assert property ((pump_uv_cmp && pump_uv_protect_on) [*6]
    |-> pump_uv_shutdown) else $error("pump fault took no action");
  pump_off_a: assert property (!pump_uv_protect_on [*2] |-> !pump_uv_shutdown)
    else $error("pump action while disabled");
  cover property (!spi_cs_n ##1 spi_cs_n);
  cover property ($rose(pump_uv_shutdown));
  cover property ($fell(error_indicator_pin_n));
endmodule // gdfcr_regs_props

bind gdfcr_regs gdfcr_regs_props chk_u (.clk_sys, .nrst, .spi_cs_n, .spi_sclk, .spi_sdo,
  .spi_sdo_oe_n, .enable_pin, .supply_uv_cmp, .pump_uv_cmp, .thermal_warn_cmp,
  .error_indicator_pin_n, .pump_uv_shutdown, .pump_uv_protect_on, .thermal_warn_to_pin,
  .pwm_mode_on, .dead_time_sel);

/* File: tb/gdfcr_regs_test.sv */
// self-checking bench for the fault and control register bank
module gdfcr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic nrst;
  logic enable_pin;
  logic [15:0] flt;
  logic [7:0] v;
  logic [15:0] rx;
  wire spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n;
  wire error_indicator_pin_n, pump_uv_shutdown;
  wire [7:0] ctl;
  int failures = 0;
  int total_checks = 0;
  localparam int PBIT [16] = '{10, 8, 5, 4, 2, 1, 0, 6, 6, 6, 7, 7, 7, 7, 7, 7};
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  gdfcr_regs dut_u (.clk_sys, .nrst, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
    .enable_pin, .supply_uv_cmp(flt[0]), .pump_uv_cmp(flt[1]), .thermal_warn_cmp(flt[2]),
    .thermal_shut_cmp(flt[3]), .regulator_oc_cmp(flt[4]), .regulator_uv_cmp(flt[5]),
    .regulator_ov_cmp(flt[6]), .amp_a_overcurrent(flt[7]), .amp_b_overcurrent(flt[8]),
    .amp_c_overcurrent(flt[9]), .phase_a_high_switch_trip(flt[10]),
    .phase_a_low_switch_trip(flt[11]), .phase_b_high_switch_trip(flt[12]),
    .phase_b_low_switch_trip(flt[13]), .phase_c_high_switch_trip(flt[14]),
    .phase_c_low_switch_trip(flt[15]), .error_indicator_pin_n, .pump_uv_shutdown,
    .pump_uv_protect_on(ctl[7]), .backemf_hold_on(ctl[6]), .thermal_warn_to_pin(ctl[5]),
    .pwm_mode_on(ctl[4]), .dead_time_sel(ctl[3:2]), .rdson_sense_on(ctl[1]),
    .current_amp_hold_on(ctl[0]));
  gdfcr_spi_host host_u (.clk_sys, .spi_sdo, .spi_sdo_oe_n, .spi_cs_n, .spi_sclk, .spi_sdi);
  // ----
  // access and compare tasks
  // ----
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    host_u.xfer({1'b0, a, d}, 16, rx);
  endtask
  task automatic rchk(input string what, input logic [2:0] a, input logic [11:0] exp);
    host_u.xfer({1'b1, a, 12'h000}, 16, rx);
    chk(what, rx[11:0], exp);
  endtask
  function automatic logic [11:0] pri_exp(input int i, input logic held);
    logic [11:0] p;
    p = 12'h000;
    p[PBIT[i]] = 1'b1;
    p[11] = (i != 2);
    return (held || i != 2) ? p : 12'h000;
  endfunction
  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    failures++;
    test_done();
  end
  // ----
  // tests
  // ----
  initial begin
    nrst = 1'b0;
    enable_pin = 1'b1;
    flt = 16'h0000;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rchk("stat1", 3'h0, 12'h000);
    rchk("stat2", 3'h1, 12'h000);
    rchk("ctrl", 3'h2, 12'h3A4);
    chk("ctl", {4'h0, ctl}, 12'h0A4);
    $display("reset test done");
    for (int d = 0; d < 4; d++) begin
      v = {d[1:0], d[1:0], d[1:0], d[1:0]};
      wr(3'h2, {4'h0, v});
      rchk("ctrl", 3'h2, {4'h3, v});
      chk("ctl", {4'h0, ctl}, {4'h0, v});
    end
    $display("field test done");
    wr(3'h2, 12'h6FF);
    rchk("ctrl", 3'h2, 12'h6FF);
    wr(3'h2, 12'hE00);
    rchk("ctrl", 3'h2, 12'h6FF);
    wr(3'h2, 12'h3FF);
    wr(3'h2, 12'h3A4);
    rchk("ctrl", 3'h2, 12'h3A4);
    $display("lock test done");
    host_u.xfer({1'b0, 3'h2, 12'h000}, 15, rx);
    wr(3'h6, 12'h300);
    wr(3'h0, 12'hFFF);
    wr(3'h1, 12'hFFF);
    rchk("ctrl", 3'h2, 12'h3A4);
    rchk("stat1", 3'h0, 12'h000);
    rchk("stat2", 3'h1, 12'h000);
    rchk("reg3", 3'h3, 12'h000);
    $display("refusal test done");
    for (int i = 0; i < 16; i++) begin
      flt[i] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rchk("stat1", 3'h0, pri_exp(i, 1'b1));
      rchk("stat2", 3'h1, (i > 6) ? 12'h001 << (18 - i) : 12'h000);
      chk("pin", {11'h0, error_indicator_pin_n}, 12'h000);
      chk("shut", {11'h0, pump_uv_shutdown}, {11'h0, i == 1});
      flt[i] <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rchk("stat1", 3'h0, pri_exp(i, 1'b0));
      if (i % 2) begin
        enable_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        enable_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
      end else begin
        wr(3'h2, 12'hBA4);
      end
      rchk("stat1", 3'h0, 12'h000);
      rchk("stat2", 3'h1, 12'h000);
      rchk("ctrl", 3'h2, 12'h3A4);
      chk("pin", {11'h0, error_indicator_pin_n}, 12'h001);
    end
    $display("fault test done");
    wr(3'h2, 12'h004);
    flt[2] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rchk("stat1", 3'h0, 12'h020);
    chk("pin", {11'h0, error_indicator_pin_n}, 12'h001);
    flt[2] <= 1'b0;
    flt[1] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rchk("stat1", 3'h0, 12'h900);
    chk("shut", {11'h0, pump_uv_shutdown}, 12'h000);
    chk("pin", {11'h0, error_indicator_pin_n}, 12'h000);
    flt[1] <= 1'b0;
    wr(3'h2, 12'hBA4);
    rchk("stat1", 3'h0, 12'h000);
    rchk("ctrl", 3'h2, 12'h3A4);
    $display("option test done");
    test_done();
  end
endmodule // gdfcr_regs_test

/* File: tb/gdfcr_spi_host.sv */
// host model: serial master that sends frames to the register bank
module gdfcr_spi_host (
  input wire clk_sys,
  input wire spi_sdo,
  input wire spi_sdo_oe_n,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end
  // ----
  // one frame of nbits, 8 system clocks per serial clock
  // ----
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      spi_sclk <= 1'b1;
      spi_sdi <= w[15 - i];
      repeat (4) @(posedge clk_sys);
      spi_sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rx = {rx[14:0], spi_sdo & ~spi_sdo_oe_n};
    end
    spi_cs_n <= 1'b1;
    // released line must not keep the last bit
    spi_sdi <= ~spi_sdi;
    repeat (20) @(posedge clk_sys);
  endtask
endmodule // gdfcr_spi_host
